// file: inc/smem_defs.vh
`ifndef SMEM_DEFS_VH
`define SMEM_DEFS_VH
// register byte offsets
`define SMEM_REG_CTRL       8'h00
`define SMEM_REG_STATUS     8'h04
`define SMEM_REG_MASK       8'h08
`define SMEM_REG_POS_LIMIT  8'h0C
`define SMEM_REG_SPD_LIMIT  8'h10
`define SMEM_REG_OVS_LEVEL  8'h14
`define SMEM_REG_OVS2_LEVEL 8'h18
`define SMEM_REG_ALARM      8'h1C
`define SMEM_REG_CMD_SPEED  8'h20
// ctrl fields
`define SMEM_CTRL_ENABLE    0
`define SMEM_CTRL_CLEAR     1
// status bit positions
`define SMEM_ST_POS_DEV     0
`define SMEM_ST_SPD_DEV     1
`define SMEM_ST_OVS         2
`define SMEM_ST_OVS2        3
// alarm codes
`define SMEM_MAIN_POS       8'h18
`define SMEM_MAIN_OVS       8'h1A
`define SMEM_SUB_0          4'h0
`define SMEM_SUB_1          4'h1
// reset values
`define SMEM_RST_LIMIT      32'h0000_0000
`define SMEM_RST_MASK       4'h0
`define SMEM_RST_CTRL       1'b1
// control cycle: 62.5 us at 250 MHz
// 62500 ns times 250 MHz over 1000 gives 15625 clocks
`define SMEM_CYCLE_CNT      16'h3D09
`endif

// file: core/smem_tick.v
`timescale 1ns/100ps
`include "smem_defs.vh"
module smem_tick #(
    parameter [15:0] CYCLE_CNT = `SMEM_CYCLE_CNT
) (
    input  wire clk_i,
    input  wire rst_i,
    output reg  tick_o
);
    reg [15:0] cnt;
    always @(posedge clk_i) begin
        if (rst_i) begin
            cnt    <= 16'h0000;
            tick_o <= 1'b0;
        end else if (cnt == CYCLE_CNT - 16'h0001) begin
            cnt    <= 16'h0000;
            tick_o <= 1'b1;
        end else begin
            cnt    <= cnt + 16'h0001;
            tick_o <= 1'b0;
        end
    end
endmodule

// file: core/smem_monitor.v
// What this block does
// (R1) position deviation magnitude above position_deviation_limit raises alarm 24 sub 0.
// (R2) command speed minus actual speed above speed_deviation_limit raises alarm 24 sub 1.
// (R3) speed_deviation_limit of zero disables speed deviation detection completely.
// (R4) either over-travel inhibit forces internal command speed to zero two clocks later, after its two-flop synchronizer.
// (R5) motor speed magnitude above overspeed_level raises alarm 26 sub 0.
// (R6) motor speed magnitude above second_overspeed_level raises alarm 26 sub 1.
// (R7) compare once per control cycle; first alarm code latched until cleared.
`timescale 1ns/100ps
`include "smem_defs.vh"
module smem_monitor #(
    parameter [15:0] CYCLE_CNT = `SMEM_CYCLE_CNT
) (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire [31:0] wb_adr_i,
    input  wire [31:0] wb_dat_i,
    input  wire [3:0]  wb_sel_i,
    input  wire        wb_we_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire [31:0] pos_deviation_i,
    input  wire [31:0] cmd_speed_i,
    input  wire [31:0] motor_speed_i,
    input  wire        inhibit_cw_i,
    input  wire        inhibit_ccw_i,
    output reg  [31:0] cmd_speed_o,
    output reg         alarm_o,
    output reg  [7:0]  alarm_main_o,
    output reg  [3:0]  alarm_sub_o,
    output wire        irq_o
);
    function [31:0] mag;
        input [31:0] v;
        begin
            mag = v[31] ? (~v + 32'h0000_0001) : v;
        end
    endfunction

    function [31:0] lane_wr;
        input [31:0] old;
        input [31:0] dat;
        input [3:0]  sel;
        integer k;
        begin
            lane_wr = old;
            for (k = 0; k < 4; k = k + 1) begin
                if (sel[k]) begin
                    lane_wr[k*8 +: 8] = dat[k*8 +: 8];
                end
            end
        end
    endfunction

    reg        inh_cw_s1;
    reg        inh_cw_s2;
    reg        inh_ccw_s1;
    reg        inh_ccw_s2;
    reg        enable;
    wire [3:0] status;
    reg [3:0]  mask;
    reg [31:0] position_deviation_limit;
    reg [31:0] speed_deviation_limit;
    reg [31:0] overspeed_level;
    reg [31:0] second_overspeed_level;
    reg [3:0]  hit;
    wire       tick;
    wire       inhibit;
    wire [31:0] eff_cmd;
    wire [32:0] spd_dev;
    wire [31:0] spd_mag;
    wire       acc;
    wire       wr;
    wire [7:0] adr;
    wire [3:0] st_clr;
    wire [3:0] st_set;
    wire       alarm_clr;

    smem_tick #(
        .CYCLE_CNT (CYCLE_CNT)
    ) u_tick (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .tick_o (tick)
    );

    // inhibit pins are asynchronous to the control clock
    always @(posedge clk_i) begin
        if (rst_i) begin
            inh_cw_s1  <= 1'b0;
            inh_cw_s2  <= 1'b0;
            inh_ccw_s1 <= 1'b0;
            inh_ccw_s2 <= 1'b0;
        end else begin
            inh_cw_s1  <= inhibit_cw_i;
            inh_cw_s2  <= inh_cw_s1;
            inh_ccw_s1 <= inhibit_ccw_i;
            inh_ccw_s2 <= inh_ccw_s1;
        end
    end

    assign inhibit = inh_cw_s2 | inh_ccw_s2;
    // instant stop: the deviation jumps here, so the limit needs margin
    assign eff_cmd = inhibit ? 32'h0000_0000 : cmd_speed_i; // [R4]
    assign spd_dev = {eff_cmd[31], eff_cmd} - {motor_speed_i[31], motor_speed_i};
    assign spd_mag = mag(motor_speed_i);

    always @(posedge clk_i) begin
        if (rst_i) begin
            cmd_speed_o <= 32'h0000_0000;
        end else begin
            cmd_speed_o <= eff_cmd; // [R4]
        end
    end

    // only positive excess counts: command ahead of the motor
    always @* begin
        hit = 4'h0;
        hit[`SMEM_ST_POS_DEV] = mag(pos_deviation_i) > position_deviation_limit; // [R1]
        hit[`SMEM_ST_SPD_DEV] = (speed_deviation_limit != 32'h0000_0000) && !spd_dev[32] &&
                                (spd_dev[31:0] > speed_deviation_limit); // [R2] [R3]
        hit[`SMEM_ST_OVS]     = spd_mag > overspeed_level; // [R5]
        hit[`SMEM_ST_OVS2]    = spd_mag > second_overspeed_level; // [R6]
    end

    assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    // a write lands at the edge where the master sees ack, not one edge before it
    assign wr  = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
    assign adr = wb_adr_i[7:0];

    assign st_clr    = (wr && adr == `SMEM_REG_STATUS && wb_sel_i[0]) ? wb_dat_i[3:0] : 4'h0;
    assign st_set    = (tick && enable) ? hit : 4'h0; // [R7]
    assign alarm_clr = wr && adr == `SMEM_REG_CTRL && wb_sel_i[0] && wb_dat_i[`SMEM_CTRL_CLEAR];

    // write-one-to-clear, but a new event in the same cycle wins so none is lost
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : st_bit
            reg st_q;
            always @(posedge clk_i) begin
                if (rst_i) begin
                    st_q <= 1'b0;
                end else if (st_set[g]) begin
                    st_q <= 1'b1;
                end else if (st_clr[g]) begin
                    st_q <= 1'b0;
                end
            end
            assign status[g] = st_q;
        end
    endgenerate

    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o                 <= 1'b0;
            wb_dat_o                 <= 32'h0000_0000;
            enable                   <= `SMEM_RST_CTRL;
            mask                     <= `SMEM_RST_MASK;
            position_deviation_limit <= `SMEM_RST_LIMIT;
            speed_deviation_limit    <= `SMEM_RST_LIMIT;
            overspeed_level          <= `SMEM_RST_LIMIT;
            second_overspeed_level   <= `SMEM_RST_LIMIT;
            alarm_o                  <= 1'b0;
            alarm_main_o             <= 8'h00;
            alarm_sub_o              <= 4'h0;
        end else begin
            wb_ack_o <= acc;
            if (wr && adr == `SMEM_REG_CTRL && wb_sel_i[0]) begin
                enable <= wb_dat_i[`SMEM_CTRL_ENABLE];
            end
            if (wr && adr == `SMEM_REG_MASK && wb_sel_i[0]) begin
                mask <= wb_dat_i[3:0];
            end
            if (wr && adr == `SMEM_REG_POS_LIMIT) begin
                position_deviation_limit <= lane_wr(position_deviation_limit, wb_dat_i, wb_sel_i);
            end
            if (wr && adr == `SMEM_REG_SPD_LIMIT) begin
                speed_deviation_limit <= lane_wr(speed_deviation_limit, wb_dat_i, wb_sel_i);
            end
            if (wr && adr == `SMEM_REG_OVS_LEVEL) begin
                overspeed_level <= lane_wr(overspeed_level, wb_dat_i, wb_sel_i);
            end
            if (wr && adr == `SMEM_REG_OVS2_LEVEL) begin
                second_overspeed_level <= lane_wr(second_overspeed_level, wb_dat_i, wb_sel_i);
            end
            // first alarm only; one raised in the clearing cycle beats the clear
            if (tick && enable && hit != 4'h0 && (!alarm_o || alarm_clr)) begin // [R7]
                alarm_o <= 1'b1;
                if (hit[`SMEM_ST_POS_DEV]) begin
                    alarm_main_o <= `SMEM_MAIN_POS; // [R1]
                    alarm_sub_o  <= `SMEM_SUB_0;
                end else if (hit[`SMEM_ST_SPD_DEV]) begin
                    alarm_main_o <= `SMEM_MAIN_POS; // [R2]
                    alarm_sub_o  <= `SMEM_SUB_1;
                end else if (hit[`SMEM_ST_OVS]) begin
                    alarm_main_o <= `SMEM_MAIN_OVS; // [R5]
                    alarm_sub_o  <= `SMEM_SUB_0;
                end else begin
                    alarm_main_o <= `SMEM_MAIN_OVS; // [R6]
                    alarm_sub_o  <= `SMEM_SUB_1;
                end
            end else if (alarm_clr) begin
                alarm_o      <= 1'b0;
                alarm_main_o <= 8'h00;
                alarm_sub_o  <= 4'h0;
            end
            if (acc && !wb_we_i) begin
                case (adr)
                    `SMEM_REG_CTRL:       wb_dat_o <= {31'h0000_0000, enable};
                    `SMEM_REG_STATUS:     wb_dat_o <= {28'h000_0000, status};
                    `SMEM_REG_MASK:       wb_dat_o <= {28'h000_0000, mask};
                    `SMEM_REG_POS_LIMIT:  wb_dat_o <= position_deviation_limit;
                    `SMEM_REG_SPD_LIMIT:  wb_dat_o <= speed_deviation_limit;
                    `SMEM_REG_OVS_LEVEL:  wb_dat_o <= overspeed_level;
                    `SMEM_REG_OVS2_LEVEL: wb_dat_o <= second_overspeed_level;
                    `SMEM_REG_ALARM:      wb_dat_o <= {19'h0_0000, alarm_o, alarm_sub_o, alarm_main_o};
                    `SMEM_REG_CMD_SPEED:  wb_dat_o <= cmd_speed_o;
                    default:              wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign irq_o = |(status & mask);
endmodule

// file: tb/smem_monitor_chk.sv
`timescale 1ns/100ps
`include "smem_defs.vh"
module smem_chk #(
    parameter [15:0] CYCLE_CNT = 16'h0008
) (
    input wire        clk_i,
    input wire        rst_i,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire        wb_ack_o,
    input wire        inhibit_cw_i,
    input wire        inhibit_ccw_i,
    input wire [31:0] cmd_speed_i,
    input wire [31:0] cmd_speed_o,
    input wire        alarm_o,
    input wire [7:0]  alarm_main_o,
    input wire [3:0]  alarm_sub_o
);
    // mirrors the control-cycle count; a registered tick may lag it by one
    logic [15:0] cnt;
    wire         inh = inhibit_cw_i | inhibit_ccw_i;
    always @(posedge clk_i) begin
        cnt <= (rst_i || cnt == CYCLE_CNT - 16'h0001) ? 16'h0000 : cnt + 16'h0001;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_inh;
        inh [*3];
    endsequence
    a_ack_next: assert property (s_req |=> wb_ack_o) else $error("request not acknowledged");
    a_ack_pulse: assert property ($rose(wb_ack_o) |=> !wb_ack_o) else $error("ack longer than one cycle");
    a_inhibit_zero:
        assert property (s_inh |=> cmd_speed_o == 32'h0) else $error("command speed not forced to zero");
    a_cmd_pass:
        assert property ((!inh) [*3] |=> cmd_speed_o == $past(cmd_speed_i)) else $error("command speed not passed");
    a_alarm_hold:
        assert property (alarm_o && !(wb_cyc_i && wb_we_i) |=> alarm_o && $stable(alarm_main_o)
            && $stable(alarm_sub_o)) else $error("latched alarm changed");
    a_tick_only:
        assert property ($rose(alarm_o) |-> cnt == 16'h0001) else $error("alarm raised off the control tick");
    a_idle_code:
        assert property (!alarm_o |-> alarm_main_o == 8'h00 && alarm_sub_o == 4'h0)
            else $error("alarm code shown without an alarm");
    a_main_code:
        assert property (alarm_o |-> alarm_main_o == `SMEM_MAIN_POS || alarm_main_o == `SMEM_MAIN_OVS)
            else $error("bad main alarm code");
    a_sub_code:
        assert property (alarm_o |-> alarm_sub_o <= `SMEM_SUB_1) else $error("bad sub alarm code");
endmodule
bind smem_monitor smem_chk #(.CYCLE_CNT(CYCLE_CNT)) smem_chk_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_ack_o, .inhibit_cw_i, .inhibit_ccw_i, .cmd_speed_i, .cmd_speed_o, .alarm_o,
    .alarm_main_o, .alarm_sub_o);

// file: tb/smem_monitor_bench.sv
`timescale 1ns/100ps
`include "smem_defs.vh"
module smem_monitor_bench;
    localparam logic [31:0] B = 32'h7FFF_FFFF;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, pos_deviation_i = 32'h0, cmd_speed_i = 32'h0;
    logic [31:0] motor_speed_i = 32'h0;
    logic [3:0]  wb_sel_i = 4'hF;
    logic        wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, inhibit_cw_i = 1'b0, inhibit_ccw_i = 1'b0;
    wire  [31:0] wb_dat_o, cmd_speed_o;
    wire         wb_ack_o, alarm_o, irq_o;
    wire  [7:0]  alarm_main_o;
    wire  [3:0]  alarm_sub_o;
    int          n_errors = 0;
    int          checks_done = 0;
    logic [31:0] rd;
    logic [31:0] tbl [0:6][0:7];
    smem_monitor #(.CYCLE_CNT(16'h0008)) smem_monitor_i (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i,
        .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .pos_deviation_i, .cmd_speed_i, .motor_speed_i,
        .inhibit_cw_i, .inhibit_ccw_i, .cmd_speed_o, .alarm_o, .alarm_main_o, .alarm_sub_o, .irq_o);
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wb(input logic [7:0] adr, input logic we, input logic [31:0] dat);
        @(posedge clk_i);
        wb_adr_i <= {24'h0, adr};
        wb_we_i <= we;
        wb_dat_i <= dat;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic drive(input logic [31:0] p, input logic [31:0] c, input logic [31:0] m);
        @(posedge clk_i);
        pos_deviation_i <= p;
        cmd_speed_i <= c;
        motor_speed_i <= m;
    endtask
    task automatic conclude;
        $display("mismatches %0d comparisons %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #60000;
        n_errors++;
        conclude;
    end
    initial begin
        // pos, cmd, motor, pos lim, spd lim, ovs, ovs2, alarm word
        tbl[0] = '{32'h65, 32'h0, 32'h0, 32'h64, B, B, B, 32'h1018};
        tbl[1] = '{32'h64, 32'h0, 32'h0, 32'h64, B, B, B, 32'h0};
        tbl[2] = '{32'h0, 32'h1F4, 32'h12C, B, 32'hC7, B, B, 32'h1118};
        tbl[3] = '{32'h0, 32'h1F4, 32'h12C, B, 32'h0, B, B, 32'h0};
        tbl[4] = '{32'h0, 32'h0, 32'hFFFF_F82F, B, B, 32'h7D0, B, 32'h101A};
        tbl[5] = '{32'h0, 32'h0, 32'hBB9, B, B, B, 32'hBB8, 32'h111A};
        tbl[6] = '{32'h65, 32'h0, 32'hBB9, 32'h64, B, 32'h7D0, 32'hBB8, 32'h1018};
        for (int r = 0; r < 7; r++) begin
            // inputs idle through reset, since limits come up at zero
            drive(32'h0, 32'h0, 32'h0);
            rst_i <= 1'b1;
            repeat (2) @(posedge clk_i);
            rst_i <= 1'b0;
            for (int k = 0; k < 4; k++) begin
                wb(8'h0C + 8'(4 * k), 1'b1, tbl[r][3 + k]);
            end
            drive(tbl[r][0], tbl[r][1], tbl[r][2]);
            repeat (20) @(posedge clk_i);
            wb(`SMEM_REG_ALARM, 1'b0, 32'h0);
            check(rd, tbl[r][7]);
            check({19'h0, alarm_o, alarm_sub_o, alarm_main_o}, tbl[r][7]);
        end
        wb(`SMEM_REG_STATUS, 1'b0, 32'h0);
        check(rd, 32'hD);
        wb(`SMEM_REG_MASK, 1'b1, 32'h4);
        @(posedge clk_i);
        check({31'h0, irq_o}, 32'h1);
        drive(32'h0, 32'h0, 32'h0);
        repeat (10) @(posedge clk_i);
        wb(`SMEM_REG_STATUS, 1'b1, 32'hD);
        @(posedge clk_i);
        check({31'h0, irq_o}, 32'h0);
        wb(8'h40, 1'b0, 32'h0);
        check(rd, 32'h0);
        wb(`SMEM_REG_CTRL, 1'b1, 32'h3);
        @(posedge clk_i);
        check({31'h0, alarm_o}, 32'h0);
        drive(32'h0, 32'h0, 32'hBB9);
        repeat (20) @(posedge clk_i);
        wb(`SMEM_REG_ALARM, 1'b0, 32'h0);
        check(rd, 32'h101A);
        for (int i = 0; i < 2; i++) begin
            drive(32'h0, 32'h7B, 32'h0);
            repeat (4) @(posedge clk_i);
            check(cmd_speed_o, 32'h7B);
            wb(`SMEM_REG_CMD_SPEED, 1'b0, 32'h0);
            check(rd, 32'h7B);
            {inhibit_ccw_i, inhibit_cw_i} <= 2'(1 << i);
            repeat (4) @(posedge clk_i);
            check(cmd_speed_o, 32'h0);
            inhibit_cw_i <= 1'b0;
            inhibit_ccw_i <= 1'b0;
        end
        // disabled monitor: clear the alarm, then an over-speed must raise nothing
        wb(`SMEM_REG_CTRL, 1'b1, 32'h2);
        @(posedge clk_i);
        check({31'h0, alarm_o}, 32'h0);
        drive(32'h0, 32'h0, 32'hBB9);
        repeat (20) @(posedge clk_i);
        check({31'h0, alarm_o}, 32'h0);
        drive(32'h0, 32'h0, 32'h0);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        check({31'h0, alarm_o}, 32'h0);
        for (int k = 0; k < 7; k++) begin
            wb(8'(4 * k), 1'b0, 32'h0);
            check(rd, {31'h0, k == 0});
        end
        conclude;
    end
endmodule
